// >>> src/peripheral_dma_channel.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// - Full duplex programs both directions at once
// - Current and next pointers are 32 bits
// - 16-bit counters, readable at any time
// - Enable status, set by enable/disable command bits
// - Pointer steps by 1, 2 or 4
// - Rewritten pointer used without stopping
// - Current counter decrements; next untouched until zero
// - Both counters zero: stop, raise end flag
// - Next pair reloads current, next cleared, resume
// - Receive end set at zero; receive counter write clears
// - Transmit end set at zero; transmit counter write clears
// - Receive full set; transmit counter write clears
// - Transmit empty set; transmit counter write clears
// - Receive ready: request bus, read holding, write memory
// - Transmit ready: request bus, read memory, fill holding
// - Receive counter zero halts; nonzero runs if enabled
// - Half duplex shares one pointer/counter set
// - Full duplex has separate receive and transmit sets
// - Flags go back to the peripheral
// - Ten registers at offsets from 0x100
// - Control bits 0,1,8,9; zero writes do nothing
// - Half duplex: enables exclusive, disable stops both
// - Status bit 0 receive, bit 8 transmit enable
module peripheral_dma_channel
  import dma_chan_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic half_duplex,
  input wire logic [1:0] unit_size,
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire logic [31:0] rx_holding_data,
  output hold_port_t hold,
  input wire logic bus_grant,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output mem_req_t mem,
  output dma_flags_t flags
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Pointer step for one data unit
  function automatic logic [31:0] step_of(input logic [1:0] size);
    case (size)
      SIZE_BYTE: step_of = STEP_BYTE;
      SIZE_HALF: step_of = STEP_HALF;
      default: step_of = STEP_WORD;
    endcase
  endfunction

  // Storage slot of a direction; half duplex folds both onto slot 0
  function automatic logic slot_of(input logic half, input logic dir);
    slot_of = dir & ~half;
  endfunction

  chan_state_t st_r;
  chan_state_t st_nxt;
  logic rs;
  logic ts;
  logic [31:0] step;
  logic set_rx_end;
  logic set_tx_end;
  logic set_rx_full;
  logic set_tx_empty;
  logic rx_done;
  logic tx_done;

  assign rs = slot_of(half_duplex, DIR_RX);
  assign ts = slot_of(half_duplex, DIR_TX);
  assign step = step_of(unit_size);
  assign rx_done = (st_r.fsm == S_RX_WR) && mem_ack;
  assign tx_done = (st_r.fsm == S_TX_RD) && mem_ack;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic d;
    logic s;
    logic done;
    st_nxt = st_r;
    d = DIR_RX;
    s = rs;
    done = 1'b0;
    set_rx_end = 1'b0;
    set_tx_end = 1'b0;
    set_rx_full = 1'b0;
    set_tx_empty = 1'b0;
    st_nxt.hold.rd = 1'b0;
    st_nxt.hold.wr = 1'b0;
    st_nxt.tx_put = 1'b0;
    st_nxt.rdata = 32'h0;

    // Transfer sequencer
    case (st_r.fsm)
      S_IDLE: begin
        if (!st_r.tx_put && st_r.rx_en && rx_ready && st_r.cnt[rs] != CNT_ZERO) begin
          st_nxt.mem.req = 1'b1;
          st_nxt.fsm = S_RX_REQ;
        end else if (!st_r.tx_put && st_r.tx_en && tx_ready && st_r.cnt[ts] != CNT_ZERO) begin
          st_nxt.mem.req = 1'b1;
          st_nxt.fsm = S_TX_REQ;
        end
      end
      S_RX_REQ: begin
        if (bus_grant) begin
          st_nxt.hold.rd = 1'b1;
          st_nxt.mem.wdata = rx_holding_data;
          st_nxt.mem.addr = st_r.ptr[rs];
          st_nxt.mem.size = unit_size;
          st_nxt.mem.wr = 1'b1;
          st_nxt.fsm = S_RX_WR;
        end
      end
      S_RX_WR: begin
        if (mem_ack) begin
          st_nxt.mem.wr = 1'b0;
          st_nxt.mem.req = 1'b0;
          st_nxt.fsm = S_IDLE;
          done = 1'b1;
          d = DIR_RX;
          s = rs;
        end
      end
      S_TX_REQ: begin
        if (bus_grant) begin
          st_nxt.mem.addr = st_r.ptr[ts];
          st_nxt.mem.size = unit_size;
          st_nxt.mem.rd = 1'b1;
          st_nxt.fsm = S_TX_RD;
        end
      end
      S_TX_RD: begin
        if (mem_ack) begin
          st_nxt.mem.rd = 1'b0;
          st_nxt.mem.req = 1'b0;
          st_nxt.hold.wdata = mem_rdata;
          st_nxt.hold.wr = 1'b1;
          st_nxt.tx_put = 1'b1;
          st_nxt.fsm = S_IDLE;
          done = 1'b1;
          d = DIR_TX;
          s = ts;
        end
      end
      default: begin
        st_nxt.fsm = S_IDLE;
        st_nxt.mem.req = 1'b0;
        st_nxt.mem.wr = 1'b0;
        st_nxt.mem.rd = 1'b0;
      end
    endcase

    // Pointer and counter bookkeeping after one unit has landed
    if (done) begin
      if (st_r.ptr[s] == st_r.mem.addr) begin
        st_nxt.ptr[s] = st_r.ptr[s] + step;
      end // else a fresh pointer was written: keep it
      if (st_r.cnt[s] > CNT_ONE) begin
        st_nxt.cnt[s] = st_r.cnt[s] - CNT_ONE;
      end else if (st_r.ncnt[s] != CNT_ZERO) begin
        st_nxt.ptr[s] = st_r.nptr[s];
        st_nxt.cnt[s] = st_r.ncnt[s];
        st_nxt.nptr[s] = PTR_RESET;
        st_nxt.ncnt[s] = CNT_ZERO;
        set_rx_end = (d == DIR_RX);
        set_tx_end = (d == DIR_TX);
      end else begin
        st_nxt.cnt[s] = CNT_ZERO;
        set_rx_end = (d == DIR_RX);
        set_tx_end = (d == DIR_TX);
        set_rx_full = (d == DIR_RX);
        set_tx_empty = (d == DIR_TX);
      end
    end

    // Register writes win over the sequencer's pointer and counter updates
    if (reg_wr) begin
      case (reg_addr)
        OFS_RX_CUR_PTR: st_nxt.ptr[rs] = reg_wdata;
        OFS_TX_CUR_PTR: st_nxt.ptr[ts] = reg_wdata;
        OFS_RX_NXT_PTR: st_nxt.nptr[rs] = reg_wdata;
        OFS_TX_NXT_PTR: st_nxt.nptr[ts] = reg_wdata;
        OFS_RX_CUR_CNT: st_nxt.cnt[rs] = reg_wdata[15:0];
        OFS_TX_CUR_CNT: st_nxt.cnt[ts] = reg_wdata[15:0];
        OFS_RX_NXT_CNT: st_nxt.ncnt[rs] = reg_wdata[15:0];
        OFS_TX_NXT_CNT: st_nxt.ncnt[ts] = reg_wdata[15:0];
        OFS_CONTROL: begin
          if (half_duplex) begin
            // One direction at a time; any disable stops both
            if (reg_wdata[RX_DIS_BIT] || reg_wdata[TX_DIS_BIT]) begin
              st_nxt.rx_en = 1'b0;
              st_nxt.tx_en = 1'b0;
            end else if (reg_wdata[RX_EN_BIT]) begin
              st_nxt.rx_en = 1'b1;
              st_nxt.tx_en = 1'b0;
            end else if (reg_wdata[TX_EN_BIT]) begin
              st_nxt.tx_en = 1'b1;
              st_nxt.rx_en = 1'b0;
            end
          end else begin
            // Both directions programmed independently
            if (reg_wdata[RX_DIS_BIT]) begin
              st_nxt.rx_en = 1'b0;
            end else if (reg_wdata[RX_EN_BIT]) begin
              st_nxt.rx_en = 1'b1;
            end
            if (reg_wdata[TX_DIS_BIT]) begin
              st_nxt.tx_en = 1'b0;
            end else if (reg_wdata[TX_EN_BIT]) begin
              st_nxt.tx_en = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
      // Nonzero counter writes clear the matching flags
      if (reg_wdata[15:0] != CNT_ZERO) begin
        if (reg_addr == OFS_RX_CUR_CNT || reg_addr == OFS_RX_NXT_CNT) begin
          st_nxt.flags.rx_end = 1'b0;
        end
        if (reg_addr == OFS_TX_CUR_CNT || reg_addr == OFS_TX_NXT_CNT) begin
          st_nxt.flags.tx_end = 1'b0;
          st_nxt.flags.tx_empty = 1'b0;
          st_nxt.flags.rx_full = 1'b0;
        end
      end
    end

    // Hardware set beats a clear in the same cycle
    if (set_rx_end) st_nxt.flags.rx_end = 1'b1;
    if (set_tx_end) st_nxt.flags.tx_end = 1'b1;
    if (set_rx_full) st_nxt.flags.rx_full = 1'b1;
    if (set_tx_empty) st_nxt.flags.tx_empty = 1'b1;

    // Read data, answered in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        OFS_RX_CUR_PTR: st_nxt.rdata = st_r.ptr[rs];
        OFS_TX_CUR_PTR: st_nxt.rdata = st_r.ptr[ts];
        OFS_RX_NXT_PTR: st_nxt.rdata = st_r.nptr[rs];
        OFS_TX_NXT_PTR: st_nxt.rdata = st_r.nptr[ts];
        OFS_RX_CUR_CNT: st_nxt.rdata = {16'h0, st_r.cnt[rs]};
        OFS_TX_CUR_CNT: st_nxt.rdata = {16'h0, st_r.cnt[ts]};
        OFS_RX_NXT_CNT: st_nxt.rdata = {16'h0, st_r.ncnt[rs]};
        OFS_TX_NXT_CNT: st_nxt.rdata = {16'h0, st_r.ncnt[ts]};
        OFS_STATUS: begin
          st_nxt.rdata[RX_EN_BIT] = st_r.rx_en;
          st_nxt.rdata[TX_EN_BIT] = st_r.tx_en;
        end
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.fsm <= S_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_r.rdata;
  assign hold = st_r.hold;
  assign mem = st_r.mem;
  assign flags = st_r.flags;

  // ************************************************************
  // Assertions
  // ************************************************************
  logic [31:0] rx_ptr_now;
  logic [15:0] rx_cnt_now;
  logic [15:0] rx_ncnt_now;
  logic rx_quiet;

  assign rx_ptr_now = st_r.ptr[rs];
  assign rx_cnt_now = st_r.cnt[rs];
  assign rx_ncnt_now = st_r.ncnt[rs];
  assign rx_quiet = rx_done && !reg_wr && (rx_ptr_now == st_r.mem.addr);

  a_ptr_step_rx: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rx_quiet && rx_cnt_now > CNT_ONE |=> rx_ptr_now == $past(rx_ptr_now) + $past(step))
    else $error("receive pointer did not step by the unit size");

  a_cnt_dec_rx: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rx_quiet && rx_cnt_now > CNT_ONE
    |=> rx_cnt_now == $past(rx_cnt_now) - CNT_ONE && $stable(rx_ncnt_now))
    else $error("current counter not decremented alone");

  a_reload_next: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rx_quiet && rx_cnt_now == CNT_ONE && rx_ncnt_now != CNT_ZERO
    |=> rx_cnt_now == $past(rx_ncnt_now) && rx_ncnt_now == CNT_ZERO && flags.rx_end)
    else $error("next pair not reloaded into current");

  a_stop_flags: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rx_quiet && rx_cnt_now == CNT_ONE && rx_ncnt_now == CNT_ZERO
    |=> rx_cnt_now == CNT_ZERO && flags.rx_end && flags.rx_full ##1 st_r.fsm != S_RX_REQ)
    else $error("stop at zero did not raise end and full");

  a_zero_halt: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    st_r.fsm == S_IDLE && rx_cnt_now == CNT_ZERO |=> st_r.fsm != S_RX_REQ)
    else $error("receive started with a zero counter");

  a_ctrl_enable: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && reg_addr == OFS_CONTROL && !half_duplex
    |=> st_r.rx_en == ($past(reg_wdata[RX_DIS_BIT]) ? 1'b0 :
                       ($past(reg_wdata[RX_EN_BIT]) ? 1'b1 : $past(st_r.rx_en))))
    else $error("receive enable did not follow the control write");

  a_half_excl: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    half_duplex && $stable(half_duplex) && !(st_r.rx_en && st_r.tx_en)
    |=> !(st_r.rx_en && st_r.tx_en))
    else $error("half duplex enabled both directions");

  a_status_read: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && reg_addr == OFS_STATUS
    |=> reg_rdata[RX_EN_BIT] == $past(st_r.rx_en) && reg_rdata[TX_EN_BIT] == $past(st_r.tx_en))
    else $error("status read does not show the enables");

  a_end_clear: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && reg_addr == OFS_RX_NXT_CNT && reg_wdata[15:0] != CNT_ZERO && !rx_done
    |=> !flags.rx_end)
    else $error("nonzero counter write left the end flag set");

  a_grant_fetch: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    st_r.fsm == S_RX_REQ && bus_grant
    |=> hold.rd && mem.wr && mem.addr == $past(rx_ptr_now) ##1 !hold.rd)
    else $error("granted receive did not read the holding register");

  a_tx_put: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    tx_done |=> hold.wr && hold.wdata == $past(mem_rdata) && !mem.req ##1 !hold.wr)
    else $error("memory data not placed in transmit holding register");

  a_ptr_rewrite: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    tx_done && !reg_wr && st_r.ptr[ts] != st_r.mem.addr && st_r.cnt[ts] > CNT_ONE
    |=> st_r.ptr[ts] == $past(st_r.ptr[ts]))
    else $error("rewritten transmit pointer was not kept");

  a_tx_empty: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    tx_done && !reg_wr && st_r.cnt[ts] == CNT_ONE && st_r.ncnt[ts] == CNT_ZERO
    |=> st_r.cnt[ts] == CNT_ZERO && flags.tx_end && flags.tx_empty)
    else $error("transmit stop did not raise end and empty");

endmodule

// >>> include/dma_chan_pkg.sv
package dma_chan_pkg;

  // ************************************************************
  // Register map, offsets inside the served peripheral's space
  // ************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_RX_CUR_PTR = 12'h100;
  localparam logic [11:0] OFS_RX_CUR_CNT = 12'h104;
  localparam logic [11:0] OFS_TX_CUR_PTR = 12'h108;
  localparam logic [11:0] OFS_TX_CUR_CNT = 12'h10c;
  localparam logic [11:0] OFS_RX_NXT_PTR = 12'h110;
  localparam logic [11:0] OFS_RX_NXT_CNT = 12'h114;
  localparam logic [11:0] OFS_TX_NXT_PTR = 12'h118;
  localparam logic [11:0] OFS_TX_NXT_CNT = 12'h11c;
  localparam logic [11:0] OFS_CONTROL = 12'h120;
  localparam logic [11:0] OFS_STATUS = 12'h124;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned RX_EN_BIT = 0;
  localparam int unsigned RX_DIS_BIT = 1;
  localparam int unsigned TX_EN_BIT = 8;
  localparam int unsigned TX_DIS_BIT = 9;
  localparam int unsigned CNT_W = 16;
  localparam logic [31:0] PTR_RESET = 32'h0;
  localparam logic [15:0] CNT_RESET = 16'h0;
  localparam logic [15:0] CNT_ZERO = 16'h0;
  localparam logic [15:0] CNT_ONE = 16'h1;

  // ************************************************************
  // Data unit sizes and pointer steps
  // ************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] STEP_BYTE = 32'h1;
  localparam logic [31:0] STEP_HALF = 32'h2;
  localparam logic [31:0] STEP_WORD = 32'h4;
  localparam logic DIR_RX = 1'b0;
  localparam logic DIR_TX = 1'b1;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_RX_REQ = 5'h02,
    S_RX_WR  = 5'h04,
    S_TX_REQ = 5'h08,
    S_TX_RD  = 5'h10
  } fsm_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic wr;
    logic rd;
    logic req;
  } mem_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } hold_port_t;

  typedef struct packed {
    logic rx_end;
    logic tx_end;
    logic rx_full;
    logic tx_empty;
  } dma_flags_t;

  typedef struct packed {
    logic [1:0][31:0] ptr;
    logic [1:0][15:0] cnt;
    logic [1:0][31:0] nptr;
    logic [1:0][15:0] ncnt;
    logic rx_en;
    logic tx_en;
    logic tx_put;
    fsm_t fsm;
    mem_req_t mem;
    hold_port_t hold;
    dma_flags_t flags;
    logic [31:0] rdata;
  } chan_state_t;

endpackage

// >>> verif/peer_model.sv
`timescale 1ns/10ps
module peer_model
  import dma_chan_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rx_arm,
  input wire logic tx_arm,
  input wire logic [3:0] slow,
  input wire mem_req_t mem,
  input wire hold_port_t hold,
  output logic rx_ready,
  output logic tx_ready,
  output logic [31:0] rx_holding_data,
  output logic bus_grant,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] gcnt_r;
  logic [3:0] wcnt_r;
  logic [31:0] word_w;

  // ************************************************************
  // Matrix and memory side
  // ************************************************************
  // Memory content is a fixed function of the address
  assign word_w = {~mem.addr[15:0], mem.addr[15:0]};
  // Outside the ack cycle the read bus shows the inverse
  assign mem_rdata = mem_ack ? word_w : ~word_w;
  // Grant only after slow cycles of request
  assign bus_grant = mem.req && (gcnt_r >= slow);

  // Ready lines drop for one cycle after each holding access; slow grant and ack
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_ready <= 1'b0;
      tx_ready <= 1'b0;
      rx_holding_data <= 32'h0000_a000;
      gcnt_r <= 4'h0;
      wcnt_r <= 4'h0;
      mem_ack <= 1'b0;
    end else begin
      rx_ready <= rx_arm && !hold.rd;
      tx_ready <= tx_arm && !hold.wr;
      if (hold.rd) begin
        rx_holding_data <= rx_holding_data + 32'h1;
      end
      if (!mem.req) begin
        gcnt_r <= 4'h0;
      end else if (gcnt_r != 4'hf) begin
        gcnt_r <= gcnt_r + 4'h1;
      end
      if (!(mem.wr || mem.rd) || mem_ack) begin
        wcnt_r <= 4'h0;
      end else if (wcnt_r != 4'hf) begin
        wcnt_r <= wcnt_r + 4'h1;
      end
      mem_ack <= (mem.wr || mem.rd) && !mem_ack && (wcnt_r >= slow);
    end
  end
endmodule

// >>> verif/test_peripheral_dma_channel.sv
`timescale 1ns/10ps
module test_peripheral_dma_channel
  import dma_chan_pkg::*;
;
  logic clk_sys, nrst, reg_wr, reg_rd, half_duplex, rx_ready, tx_ready, bus_grant, mem_ack;
  logic rx_arm, tx_arm;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx_holding_data, mem_rdata;
  logic [1:0] unit_size;
  logic [3:0] slow;
  hold_port_t hold;
  mem_req_t mem;
  dma_flags_t flags;
  logic [31:0] wr_q[$];
  logic [31:0] rd_q[$];
  logic [31:0] hw_q[$];
  logic [31:0] wd_q[$];
  logic [1:0] sz_seen;
  int fails, checked, cyc, req_seen;

  peripheral_dma_channel peripheral_dma_channel_i (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .half_duplex(half_duplex), .unit_size(unit_size),
    .rx_ready(rx_ready), .tx_ready(tx_ready), .rx_holding_data(rx_holding_data),
    .hold(hold), .bus_grant(bus_grant), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem(mem), .flags(flags));
  peer_model peer_model_i (.clk_sys(clk_sys), .nrst(nrst), .rx_arm(rx_arm),
    .tx_arm(tx_arm), .slow(slow), .mem(mem), .hold(hold), .rx_ready(rx_ready),
    .tx_ready(tx_ready), .rx_holding_data(rx_holding_data), .bus_grant(bus_grant),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ************************************************************
  // Clock, capture and hang guard
  // ************************************************************
  always #5 clk_sys = ~clk_sys;

  // Record memory accesses and holding register writes
  always @(posedge clk_sys) begin
    cyc++;
    if (mem_ack && mem.wr) wr_q.push_back(mem.addr);
    if (mem_ack && mem.wr) wd_q.push_back(mem.wdata);
    if (mem_ack) sz_seen = mem.size;
    if (mem_ack && mem.rd) rd_q.push_back(mem.addr);
    if (hold.wr) hw_q.push_back(hold.wdata);
    if (mem.req) req_seen++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read strobe one cycle, data taken in the following cycle
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task wait_flags(input logic [3:0] m);
    int n;
    n = 0;
    while ((flags & m) !== m && n < 800) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset_map;
    for (int a = 'h100; a <= 'h128; a += 4) rd_chk(a[11:0], 32'h0);
    wr_reg(OFS_RX_CUR_PTR, 32'hdead_beef);
    rd_chk(OFS_RX_CUR_PTR, 32'hdead_beef);
    wr_reg(OFS_RX_CUR_CNT, 32'h0001_2345);
    rd_chk(OFS_RX_CUR_CNT, 32'h0000_2345);
    wr_reg(OFS_STATUS, 32'h0000_0101);
    rd_chk(OFS_STATUS, 32'h0);
    wr_reg(OFS_RX_CUR_CNT, 32'h0);
    wr_reg(OFS_RX_CUR_PTR, 32'h0);
  endtask

  task t_control;
    wr_reg(OFS_CONTROL, 32'h101);
    rd_chk(OFS_STATUS, 32'h101);
    wr_reg(OFS_CONTROL, 32'h0);
    rd_chk(OFS_STATUS, 32'h101);
    wr_reg(OFS_CONTROL, 32'h200);
    rd_chk(OFS_STATUS, 32'h1);
    req_seen = 0;
    rx_arm <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rx_arm <= 1'b0;
    check(32'(req_seen), 32'h0);
    wr_reg(OFS_CONTROL, 32'h3);
    rd_chk(OFS_STATUS, 32'h0);
  endtask

  // Receive chain with reload, once per unit size
  task t_rx_chain;
    logic [31:0] step;
    for (int s = 0; s < 3; s++) begin
      step = 32'h1 << s;
      @(posedge clk_sys);
      unit_size <= s[1:0];
      wr_reg(OFS_RX_CUR_PTR, 32'h1000);
      wr_reg(OFS_RX_CUR_CNT, 32'h2);
      if (s > 0) check({28'h0, flags}, 32'h2);
      wr_reg(OFS_TX_NXT_CNT, 32'h1);
      check({28'h0, flags}, 32'h0);
      wr_reg(OFS_TX_NXT_CNT, 32'h0);
      wr_reg(OFS_RX_NXT_PTR, 32'h2000);
      wr_reg(OFS_RX_NXT_CNT, 32'h1);
      wr_q.delete();
      wd_q.delete();
      wr_reg(OFS_CONTROL, 32'h1);
      rx_arm <= 1'b1;
      wait_flags(4'b1010);
      rx_arm <= 1'b0;
      check(32'(wr_q.size()), 32'h3);
      check(wr_q[0], 32'h1000);
      check(wr_q[1], 32'h1000 + step);
      check(wr_q[2], 32'h2000);
      check(wd_q[0], 32'ha000 + 32'(3 * s));
      check(wd_q[2], 32'ha002 + 32'(3 * s));
      check({30'h0, sz_seen}, 32'(s));
      rd_chk(OFS_RX_NXT_CNT, 32'h0);
      rd_chk(OFS_RX_CUR_CNT, 32'h0);
      check({28'h0, flags}, 32'ha);
      wr_reg(OFS_CONTROL, 32'h2);
    end
  endtask

  // Transmit with a slow matrix and word units
  task t_tx_slow;
    logic [31:0] a;
    @(posedge clk_sys);
    unit_size <= SIZE_WORD;
    slow <= 4'h3;
    wr_reg(OFS_TX_CUR_PTR, 32'h3000);
    wr_reg(OFS_TX_CUR_CNT, 32'h2);
    rd_q.delete();
    hw_q.delete();
    wr_reg(OFS_CONTROL, 32'h100);
    tx_arm <= 1'b1;
    // Move the pointer while the first word is in flight
    wait (mem.rd === 1'b1);
    wr_reg(OFS_TX_CUR_PTR, 32'h5000);
    wait_flags(4'b0101);
    tx_arm <= 1'b0;
    // Let the last holding write reach the capture
    @(posedge clk_sys);
    #1;
    check({28'h0, flags}, 32'hd);
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? 32'h3000 : 32'h5000;
      check(rd_q[i], a);
      check(hw_q[i], {~a[15:0], a[15:0]});
    end
    check(32'(hw_q.size()), 32'h2);
    rd_chk(OFS_TX_CUR_CNT, 32'h0);
    wr_reg(OFS_CONTROL, 32'h200);
    wr_reg(OFS_TX_NXT_CNT, 32'h3);
    check({28'h0, flags}, 32'h8);
    wr_reg(OFS_TX_NXT_CNT, 32'h0);
    slow <= 4'h0;
  endtask

  task t_half;
    @(posedge clk_sys);
    half_duplex <= 1'b1;
    wr_reg(OFS_CONTROL, 32'h100);
    rd_chk(OFS_STATUS, 32'h100);
    wr_reg(OFS_CONTROL, 32'h1);
    rd_chk(OFS_STATUS, 32'h1);
    wr_reg(OFS_CONTROL, 32'h200);
    rd_chk(OFS_STATUS, 32'h0);
    wr_reg(OFS_RX_CUR_CNT, 32'h7);
    rd_chk(OFS_TX_CUR_CNT, 32'h7);
    wr_reg(OFS_TX_NXT_PTR, 32'h4400);
    rd_chk(OFS_RX_NXT_PTR, 32'h4400);
    wr_reg(OFS_RX_CUR_CNT, 32'h0);
    @(posedge clk_sys);
    half_duplex <= 1'b0;
    wr_reg(OFS_RX_CUR_PTR, 32'h10);
    wr_reg(OFS_TX_CUR_PTR, 32'h20);
    rd_chk(OFS_RX_CUR_PTR, 32'h10);
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset for 20 cycles, then run every scenario
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    half_duplex = 1'b0;
    unit_size = 2'h0;
    rx_arm = 1'b0;
    tx_arm = 1'b0;
    slow = 4'h0;
    fails = 0;
    checked = 0;
    cyc = 0;
    req_seen = 0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset_map();
    t_control();
    t_rx_chain();
    t_tx_slow();
    t_half();
    finish_test();
  end
endmodule
